// >>> core/flash_cycle.sv
// One flash bus cycle: write or read on the strobe pins
module flash_cycle
	import flash_host_pkg::*;
#(
	parameter int STROBE = STROBE_CYC
) (
	// Clock and reset
	input  logic        ref_clk,
	input  logic        reset,
	// Request
	input  logic        req_valid,
	input  cyc_req_s    req,
	output logic        done,
	output logic [7:0]  rdata,
	// Pins
	output flash_pins_s pins,
	input  logic [7:0]  dq_in
);
	typedef enum logic [1:0] {
		C_IDLE   = 2'b00,
		C_SETUP  = 2'b01,
		C_STROBE = 2'b10,
		C_HOLD   = 2'b11
	} cst_e;

	typedef struct packed {
		cst_e        st;
		logic [3:0]  cnt;
		cyc_req_s    r;
		flash_pins_s p;
		logic        done;
		logic [7:0]  rd;
	} cyc_s;

	cyc_s       q_q;
	cyc_s       q_d;
	logic [7:0] dq_s;

	sync2 #(.W(8)) u_dq_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.d       (dq_in),
		.q       (dq_s)
	);

	always_comb begin
		q_d = q_q;
		q_d.done = 1'b0;
		case (q_q.st)
			C_IDLE: begin
				if (req_valid) begin
					q_d.r = req;
					q_d.p.addr = req.addr;
					q_d.p.dq_out = req.data;
					q_d.p.dq_oe_n = ~req.wr;
					q_d.p.ce_n = 1'b0;
					q_d.st = C_SETUP;
				end
			end
			C_SETUP: begin
				// Address latched by the flash as the strobe falls
				q_d.p.we_n = ~q_q.r.wr;
				q_d.p.oe_n = q_q.r.wr;
				q_d.cnt = 4'h0;
				q_d.st = C_STROBE;
			end
			C_STROBE: begin
				q_d.cnt = q_q.cnt + 4'h1;
				if (q_q.cnt == 4'(STROBE - 1)) begin
					q_d.p.we_n = 1'b1;
					q_d.p.oe_n = 1'b1;
					q_d.rd = dq_s;
					q_d.st = C_HOLD;
				end
			end
			C_HOLD: begin
				q_d.p.ce_n = 1'b1;
				q_d.p.dq_oe_n = 1'b1;
				q_d.done = 1'b1;
				q_d.st = C_IDLE;
			end
			default: q_d.st = C_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_q <= '0;
			q_q.p.dq_oe_n <= 1'b1;
			q_q.p.ce_n <= 1'b1;
			q_q.p.oe_n <= 1'b1;
			q_q.p.we_n <= 1'b1;
		end else begin
			q_q <= q_d;
		end
	end

	assign pins = q_q.p;
	assign done = q_q.done;
	assign rdata = q_q.rd;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	strobe_width_a: assert property ($fell(pins.we_n) |->
		(!pins.we_n)[*4] ##1 pins.we_n)
		else $error("write strobe width wrong");
	addr_stable_a: assert property (!pins.ce_n && $past(!pins.ce_n)
		|-> $stable(pins.addr))
		else $error("address moved inside a cycle");
	data_drive_a: assert property (!pins.we_n |-> !pins.dq_oe_n
		&& $stable(pins.dq_out))
		else $error("data not driven under write strobe");
endmodule

// >>> core/flash_erase_host.sv
// Host controller for sector erase, suspend, resume and program
// Contract
// - Erase is six writes, last 30H in sector
// - Extra sector writes within 50 us join
// - Poll erased sector until poll bit one
// - Keep erase command gaps under 50 us
// - Confirm suspension reading the erased sector
// - Program in suspend only outside erased sectors
module flash_erase_host
	import flash_host_pkg::*;
(
	// Clock and reset
	input  logic        ref_clk,
	input  logic        reset,
	// Register port
	input  logic [7:0]  reg_addr,
	input  logic [31:0] reg_wdata,
	input  logic        reg_wr,
	input  logic        reg_rd,
	output logic [31:0] reg_rdata,
	// Flash pins
	output flash_pins_s flash,
	output logic        flash_reset_n,
	input  logic [7:0]  flash_dq_in,
	input  logic        ready_busy_out
);
	typedef enum logic [3:0] {
		S_IDLE       = 4'b0000,
		S_ERASE_SEQ  = 4'b0001,
		S_ERASE_MORE = 4'b0010,
		S_ERASE_POLL = 4'b0011,
		S_SUSP_WR    = 4'b0100,
		S_SUSP_POLL  = 4'b0101,
		S_SUSPENDED  = 4'b0110,
		S_RESUME_WR  = 4'b0111,
		S_PROG_SEQ   = 4'b1000,
		S_PROG_POLL  = 4'b1001,
		S_READ       = 4'b1010,
		S_RESET      = 4'b1011
	} state_e;

	typedef struct packed {
		state_e             st;
		logic [2:0]         step;
		logic               wait_c;
		logic               req_v;
		cyc_req_s           req;
		logic [31:0]        sectors;
		logic [31:0]        pend;
		logic [31:0]        emask;
		logic [4:0]         esec;
		logic [4:0]         psec;
		logic [20:0]        paddr;
		logic [7:0]         pdata;
		logic [7:0]         last;
		logic [7:0]         rbyte;
		logic               ret_susp;
		logic               susp_pend;
		logic               fail;
		logic               refused;
		logic               prev_tog;
		logic               have_prev;
		logic [TMO_W-1:0]   tmo;
		logic [GAP_W-1:0]   gap;
		logic [RCNT_W-1:0]  rcnt;
		logic               rst_n;
		logic [31:0]        rdata;
	} ctl_s;

	ctl_s        q_q;
	ctl_s        q_d;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	logic        rb_s;
	logic [31:0] status_word;
	logic [20:0] poll_addr;
	logic        ctrl_wr;

	sync2 #(.W(1)) u_rb_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.d       (ready_busy_out),
		.q       (rb_s)
	);

	flash_cycle #(.STROBE(STROBE_CYC)) u_cycle (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.req_valid (q_q.req_v),
		.req       (q_q.req),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.pins      (flash),
		.dq_in     (flash_dq_in)
	);

	function automatic logic [4:0] low_sec(input logic [31:0] m);
		logic [4:0] s;
		s = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (m[i])
				s = 5'(i);
		end
		return s;
	endfunction

	// Unlock words shared by erase and program sequences
	function automatic cyc_req_s seq_word(input logic prog,
		input logic [2:0] step, input logic [20:0] tgt,
		input logic [7:0] data);
		cyc_req_s w;
		w.wr = 1'b1;
		case (step)
			3'h0, 3'h3: begin
				w.addr = UNLOCK_A1;
				w.data = UNLOCK_D1;
			end
			3'h1, 3'h4: begin
				w.addr = UNLOCK_A2;
				w.data = UNLOCK_D2;
			end
			3'h2: begin
				w.addr = UNLOCK_A1;
				w.data = prog ? PROG_SET : ERASE_SET;
			end
			default: begin
				w.addr = tgt;
				w.data = prog ? data : SEC_ERASE;
			end
		endcase
		if (prog && step == 3'h3) begin
			w.addr = tgt;
			w.data = data;
		end
		return w;
	endfunction

	assign poll_addr = {q_q.psec, 16'h0000};
	assign ctrl_wr = reg_wr && reg_addr == REG_CTRL;

	always_comb begin
		status_word = '0;
		status_word[ST_BUSY] = q_q.st != S_IDLE && q_q.st != S_SUSPENDED;
		status_word[ST_ERASING] = |q_q.emask;
		status_word[ST_SUSP] = q_q.st == S_SUSPENDED;
		status_word[ST_FAIL] = q_q.fail;
		status_word[ST_REFUSED] = q_q.refused;
		status_word[ST_RDY] = rb_s;
		status_word[ST_LAST_LSB +: 8] = q_q.last;
	end

	always_comb begin
		q_d = q_q;
		q_d.req_v = 1'b0;
		q_d.rdata = '0;
		if (q_q.gap != GAP_W'(WINDOW_CYC))
			q_d.gap = q_q.gap + 1'b1;
		if (reg_rd) begin
			case (reg_addr)
				REG_SECTORS: q_d.rdata = q_q.sectors;
				REG_PADDR:   q_d.rdata = {11'h000, q_q.paddr};
				REG_PDATA:   q_d.rdata = {24'h000000, q_q.pdata};
				REG_STATUS:  q_d.rdata = status_word;
				REG_RDATA:   q_d.rdata = {24'h000000, q_q.rbyte};
				default:     q_d.rdata = '0;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				REG_SECTORS: q_d.sectors = reg_wdata;
				REG_PADDR:   q_d.paddr = reg_wdata[ADDR_W-1:0];
				REG_PDATA:   q_d.pdata = reg_wdata[7:0];
				REG_STATUS: begin
					if (reg_wdata[ST_FAIL])
						q_d.fail = 1'b0;
					if (reg_wdata[ST_REFUSED])
						q_d.refused = 1'b0;
				end
				default: ;
			endcase
		end
		case (q_q.st)
			S_ERASE_SEQ, S_ERASE_MORE: begin
				if (!q_q.wait_c) begin
					q_d.req_v = 1'b1;
					q_d.wait_c = 1'b1;
					q_d.req = seq_word(1'b0,
						q_q.st == S_ERASE_MORE ? 3'h5 : q_q.step,
						{q_q.esec, 16'h0000}, 8'h00);
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					q_d.step = q_q.step + 3'h1;
					if (q_q.st == S_ERASE_MORE || q_q.step == 3'h5) begin
						// Next sector follows at once to keep the window open
						q_d.pend[q_q.esec] = 1'b0;
						q_d.gap = '0;
						if ((q_q.pend & ~(32'h1 << q_q.esec)) != 32'h0) begin
							q_d.esec = low_sec(q_q.pend & ~(32'h1 << q_q.esec));
							q_d.st = S_ERASE_MORE;
						end else begin
							q_d.st = S_ERASE_POLL;
						end
					end
				end
			end
			S_ERASE_POLL: begin
				if (!q_q.wait_c) begin
					if (q_q.susp_pend) begin
						q_d.susp_pend = 1'b0;
						q_d.st = S_SUSP_WR;
					end else begin
						q_d.req_v = 1'b1;
						q_d.wait_c = 1'b1;
						q_d.req = '{wr: 1'b0, addr: poll_addr, data: 8'h00};
					end
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					q_d.last = cyc_rdata;
					if (cyc_rdata[POLL_STATUS_BIT]) begin
						q_d.emask = '0;
						q_d.st = S_IDLE;
					end else if (cyc_rdata[LIMIT_FAIL_BIT]) begin
						q_d.fail = 1'b1;
						q_d.emask = '0;
						q_d.st = S_IDLE;
					end
				end
			end
			S_SUSP_WR, S_RESUME_WR: begin
				if (!q_q.wait_c) begin
					q_d.req_v = 1'b1;
					q_d.wait_c = 1'b1;
					q_d.req = '{wr: 1'b1, addr: ANY_ADDR,
						data: q_q.st == S_SUSP_WR ? SUSP_CMD : RESUME_CMD};
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					q_d.tmo = '0;
					q_d.have_prev = 1'b0;
					q_d.st = q_q.st == S_SUSP_WR ? S_SUSP_POLL : S_ERASE_POLL;
				end
			end
			S_SUSP_POLL: begin
				q_d.tmo = q_q.tmo + 1'b1;
				if (!q_q.wait_c) begin
					q_d.req_v = 1'b1;
					q_d.wait_c = 1'b1;
					q_d.req = '{wr: 1'b0, addr: poll_addr, data: 8'h00};
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					q_d.last = cyc_rdata;
					q_d.prev_tog = cyc_rdata[ACTIVITY_TOGGLE_BIT];
					q_d.have_prev = 1'b1;
					// Toggle stopped, poll bit high and ready pin high
					if (cyc_rdata[POLL_STATUS_BIT] && q_q.have_prev && rb_s &&
						q_q.prev_tog == cyc_rdata[ACTIVITY_TOGGLE_BIT]) begin
						q_d.st = S_SUSPENDED;
					end else if (q_q.tmo >= TMO_W'(SUSP_CYC)) begin
						q_d.fail = 1'b1;
						q_d.st = S_SUSPENDED;
					end
				end
			end
			S_PROG_SEQ: begin
				if (!q_q.wait_c) begin
					q_d.req_v = 1'b1;
					q_d.wait_c = 1'b1;
					q_d.req = seq_word(1'b1, q_q.step, q_q.paddr, q_q.pdata);
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					q_d.step = q_q.step + 3'h1;
					if (q_q.step == 3'h3)
						q_d.st = S_PROG_POLL;
				end
			end
			S_PROG_POLL, S_READ: begin
				if (!q_q.wait_c) begin
					q_d.req_v = 1'b1;
					q_d.wait_c = 1'b1;
					q_d.req = '{wr: 1'b0, addr: q_q.paddr, data: 8'h00};
				end else if (cyc_done) begin
					q_d.wait_c = 1'b0;
					if (q_q.st == S_READ) begin
						q_d.rbyte = cyc_rdata;
						q_d.st = q_q.ret_susp ? S_SUSPENDED : S_IDLE;
					end else begin
						q_d.last = cyc_rdata;
						if (cyc_rdata[POLL_STATUS_BIT] == q_q.pdata[POLL_STATUS_BIT] ||
							cyc_rdata[LIMIT_FAIL_BIT]) begin
							q_d.fail = q_q.fail |
								(cyc_rdata[POLL_STATUS_BIT] !=
								q_q.pdata[POLL_STATUS_BIT]);
							q_d.st = q_q.ret_susp ? S_SUSPENDED : S_IDLE;
						end
					end
				end
			end
			S_RESET: begin
				q_d.rcnt = q_q.rcnt + 1'b1;
				if (q_q.rcnt == RCNT_W'(RST_CYC)) begin
					q_d.rst_n = 1'b1;
					q_d.st = S_IDLE;
				end
			end
			default: ;
		endcase
		if (ctrl_wr) begin
			if (reg_wdata[CTRL_HWRESET]) begin
				q_d.st = S_RESET;
				q_d.rst_n = 1'b0;
				q_d.rcnt = '0;
				q_d.wait_c = 1'b0;
				q_d.emask = '0;
				q_d.pend = '0;
				q_d.susp_pend = 1'b0;
			end else if (reg_wdata[CTRL_ERASE]) begin
				if (q_q.st == S_IDLE && q_q.sectors != 32'h0) begin
					q_d.st = S_ERASE_SEQ;
					q_d.step = 3'h0;
					q_d.pend = q_q.sectors;
					q_d.emask = q_q.sectors;
					q_d.esec = low_sec(q_q.sectors);
					q_d.psec = low_sec(q_q.sectors);
					// Drop a suspend left over from an erase that ended
					q_d.susp_pend = 1'b0;
				end else begin
					q_d.refused = 1'b1;
				end
			end else if (reg_wdata[CTRL_SUSPEND]) begin
				if (q_q.st == S_ERASE_SEQ || q_q.st == S_ERASE_MORE ||
					q_q.st == S_ERASE_POLL)
					q_d.susp_pend = 1'b1;
				else
					q_d.refused = 1'b1;
			end else if (reg_wdata[CTRL_RESUME]) begin
				if (q_q.st == S_SUSPENDED)
					q_d.st = S_RESUME_WR;
				else
					q_d.refused = 1'b1;
			end else if (reg_wdata[CTRL_PROGRAM]) begin
				if (q_q.st == S_IDLE || (q_q.st == S_SUSPENDED &&
					!q_q.emask[q_q.paddr[20:SEC_LSB]])) begin
					q_d.st = S_PROG_SEQ;
					q_d.step = 3'h0;
					q_d.ret_susp = q_q.st == S_SUSPENDED;
				end else begin
					q_d.refused = 1'b1;
				end
			end else if (reg_wdata[CTRL_READ]) begin
				if (q_q.st == S_IDLE || q_q.st == S_SUSPENDED) begin
					q_d.st = S_READ;
					q_d.ret_susp = q_q.st == S_SUSPENDED;
				end else begin
					q_d.refused = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_q <= '0;
			q_q.rst_n <= 1'b1;
		end else begin
			q_q <= q_d;
		end
	end

	assign reg_rdata = q_q.rdata;
	assign flash_reset_n = q_q.rst_n;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	unlock_first_a: assert property (q_q.req_v && q_q.st == S_ERASE_SEQ &&
		q_q.step == 3'h0 |-> q_q.req.addr == UNLOCK_A1 &&
		q_q.req.data == UNLOCK_D1)
		else $error("erase sequence does not start with unlock");
	erase_final_a: assert property (q_q.req_v && (q_q.st == S_ERASE_MORE ||
		(q_q.st == S_ERASE_SEQ && q_q.step == 3'h5)) |->
		q_q.req.data == SEC_ERASE && q_q.emask[q_q.req.addr[20:SEC_LSB]])
		else $error("erase word misses a selected sector");
	gap_limit_a: assert property (q_q.st == S_ERASE_MORE |->
		q_q.gap < GAP_W'(WINDOW_CYC))
		else $error("erase command gap too long");
	poll_sector_a: assert property (q_q.req_v && (q_q.st == S_ERASE_POLL ||
		q_q.st == S_SUSP_POLL) |-> !q_q.req.wr &&
		q_q.emask[q_q.req.addr[20:SEC_LSB]])
		else $error("poll outside erased sectors");
	susp_bound_a: assert property (q_q.st == S_SUSP_POLL |->
		q_q.tmo <= TMO_W'(SUSP_CYC + 8))
		else $error("suspend wait not bounded");
	susp_only_a: assert property (q_q.req_v && q_q.req.wr &&
		q_q.req.data == SUSP_CMD && q_q.st != S_PROG_SEQ &&
		q_q.st != S_RESET |-> q_q.st == S_SUSP_WR && q_q.emask != 32'h0)
		else $error("suspend written outside erase");
	prog_guard_a: assert property (q_q.req_v && q_q.st == S_PROG_SEQ &&
		q_q.ret_susp |-> !q_q.emask[q_q.paddr[20:SEC_LSB]])
		else $error("program aimed at erased sector");
	prog_return_a: assert property (q_q.st == S_PROG_POLL &&
		q_q.ret_susp ##1 q_q.st != S_PROG_POLL && q_q.st != S_RESET |->
		q_q.st == S_SUSPENDED)
		else $error("program in suspend did not return");
	resume_erase_a: assert property (q_q.st == S_RESUME_WR &&
		cyc_done && !ctrl_wr |=> q_q.st == S_ERASE_POLL)
		else $error("resume did not return to erase polling");
	poll_done_a: assert property (q_q.st == S_ERASE_POLL && cyc_done &&
		cyc_rdata[POLL_STATUS_BIT] && !ctrl_wr |=> q_q.st == S_IDLE)
		else $error("erase completion missed");

	erase_done_c: cover property (q_q.st == S_ERASE_POLL ##1 q_q.st == S_IDLE);
	suspended_c: cover property (q_q.st == S_SUSP_POLL ##1
		q_q.st == S_SUSPENDED);
	prog_susp_c: cover property (q_q.st == S_PROG_POLL && q_q.ret_susp ##1
		q_q.st == S_SUSPENDED);
	refused_c: cover property ($rose(q_q.refused));
endmodule

// >>> core/sync2.sv
// Two flip-flop synchroniser for pin inputs
module sync2
	import flash_host_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  logic         ref_clk,
	input  logic         reset,
	// Data
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign q = st_q.s2;
endmodule

// >>> dv/flash_dev_model.sv
// Behavioural flash device facing the erase host pins
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter int ERASE_NS = 20000,
	parameter int PROG_NS  = 2000,
	parameter int SUSP_NS  = 4000
) (
	// Pins
	input  flash_pins_s pins,
	input  logic        reset_n,
	input  logic [7:0]  dq_in,
	output logic [7:0]  dq,
	output logic        ready_busy_out,
	// Test controls
	input  logic        fail_mode,
	output logic [31:0] erased
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RD = 0, WIN = 1, ERS = 2, SUS = 3, PRG = 4, SPR = 5;
	int          st = RD, step = 0, left = 0, pleft = 0, sw = 0;
	logic [31:0] mask = '0;
	logic [20:0] addr_q, pa;
	logic [7:0]  pd, rdv = '0;
	logic        t6 = 1'b0, t2 = 1'b0;
	logic [7:0]  mem [logic [20:0]];
	realtime     t_we = 0.0;

	initial erased = '0;
	initial ready_busy_out = 1'b1;

	function automatic logic [7:0] rv(input logic [20:0] a);
		logic m;
		m = mask[a[20:16]];
		if (st >= PRG)
			return {((a == pa) ? ~pd[7] : 1'b0), t6, 2'b00, (st == SPR),
				((a == pa || !m) ? 1'b1 : t2), 2'b00};
		if (st == WIN || st == ERS || (st == SUS && sw > 0))
			return {1'b0, t6, fail_mode, 1'b0, (st != WIN),
				(m ? t2 : 1'b1), 2'b00};
		if (st == SUS && m)
			return {5'b11001, t2, 2'b00};
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction

	task automatic seq(input logic [20:0] a, input logic [7:0] d);
		case (step)
			0, 3: step = (a == UNLOCK_A1 && d == UNLOCK_D1) ? step + 1 : 0;
			1, 4: step = (a == UNLOCK_A2 && d == UNLOCK_D2) ? step + 1 : 0;
			2: step = (d == PROG_SET) ? 6 :
				(d == ERASE_SET && st == RD) ? 3 : 0;
			5: begin
				step = 0;
				if (d == SEC_ERASE) begin
					mask = '0;
					mask[a[20:16]] = 1'b1;
					left = ERASE_NS;
					st = WIN;
				end
			end
			default: begin
				step = 0;
				pa = a;
				pd = d & rv(a);
				pleft = PROG_NS;
				st = (st == SUS) ? SPR : PRG;
			end
		endcase
	endtask

	task automatic cmd(input logic [20:0] a, input logic [7:0] d);
		t_we = $realtime;
		if (st == WIN && d == SEC_ERASE)
			mask[a[20:16]] = 1'b1;
		else if ((st == WIN || st == ERS) && d == SUSP_CMD) begin
			st = SUS;
			sw = SUSP_NS;
		end else if (st == WIN) begin
			mask = '0;
			st = RD;
		end else if (st == SUS && step == 0 && d == RESUME_CMD)
			st = ERS;
		else if (st == RD || st == SUS)
			seq(a, d);
	endtask

	always @(negedge pins.we_n)
		if (!pins.ce_n) begin
			addr_q = pins.addr;
			t_we = $realtime;
		end

	always @(posedge pins.we_n)
		if (reset_n && !pins.ce_n)
			cmd(addr_q, dq_in);

	always @(negedge pins.oe_n)
		if (!pins.ce_n) begin
			rdv = rv(pins.addr);
			t6 = ~t6;
			t2 = ~t2;
		end

	// Released lines show the inverse of the last byte
	assign dq = (!pins.ce_n && !pins.oe_n) ? rdv : ~rdv;

	always @(negedge reset_n) begin
		st = RD;
		step = 0;
		mask = '0;
	end

	// Internal time base of the embedded algorithms
	always #100 begin
		if (sw > 0)
			sw -= 100;
		if (st == WIN && $realtime - t_we >= 50000.0)
			st = ERS;
		if (st == ERS && !fail_mode)
			left -= 100;
		if (st == ERS && left <= 0) begin
			foreach (mem[k])
				if (mask[k[20:16]])
					mem[k] = 8'hff;
			erased = mask;
			mask = '0;
			st = RD;
		end
		if (st >= PRG)
			pleft -= 100;
		if (st >= PRG && pleft <= 0) begin
			mem[pa] = pd;
			st = (st == SPR) ? SUS : RD;
		end
		ready_busy_out = st == RD || (st == SUS && sw <= 0);
	end
endmodule

// >>> dv/test_sector_erase_suspend_control.sv
// Self-checking bench for the sector erase host
module test_sector_erase_suspend_control
	import flash_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        fail_mode = 1'b0;
	logic [31:0] reg_rdata, erased, s, mask;
	flash_pins_s flash;
	logic        flash_reset_n, ready_busy_out;
	logic [7:0]  dq, bus_dq, pd;
	logic [20:0] pa;
	int          error_cnt = 0, tests_run = 0, cyc = 0;

	assign bus_dq = flash.dq_oe_n ? dq : flash.dq_out;

	flash_erase_host dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .flash, .flash_reset_n, .flash_dq_in(bus_dq),
		.ready_busy_out);
	flash_dev_model model (.pins(flash), .reset_n(flash_reset_n),
		.dq_in(bus_dq), .dq, .ready_busy_out, .fail_mode, .erased);

	initial forever #20 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_st(input int b, input logic v);
		rd(REG_STATUS, s);
		for (int i = 0; i < 4000 && s[b] !== v; i++)
			rd(REG_STATUS, s);
		if (s[b] !== v)
			error_cnt++;
	endtask

	function automatic logic [31:0] exp_st(input logic ers, susp, fail,
		refd);
		exp_st = '0;
		exp_st[ST_ERASING] = ers;
		exp_st[ST_SUSP] = susp;
		exp_st[ST_FAIL] = fail;
		exp_st[ST_REFUSED] = refd;
	endfunction

	task automatic op(input int b);
		wr(REG_CTRL, 32'h1 << b);
		wait_st(ST_BUSY, 1'b0);
	endtask

	task automatic prog(input logic [20:0] a, input logic [7:0] d);
		wr(REG_PADDR, 32'(a));
		wr(REG_PDATA, 32'(d));
		op(CTRL_PROGRAM);
	endtask

	task automatic rdb(input logic [20:0] a, input logic [7:0] d);
		wr(REG_PADDR, 32'(a));
		op(CTRL_READ);
		rd(REG_RDATA, s);
		chk(s, 32'(d));
	endtask

	initial begin
		void'($urandom(51590));
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		// Ready pin needs its synchroniser filled first
		repeat (2) @(posedge ref_clk);
		rd(REG_STATUS, s);
		chk(s, 32'h20);
		rd(REG_CTRL, s);
		chk(s, 32'h0);
		rd(8'h3c, s);
		chk(s, 32'h0);
		// Corner set, then random set, sector 1 spared
		for (int n = 0; n < 2; n++) begin
			pa = {5'd1, n[0], 15'($urandom)};
			pd = 8'($urandom);
			prog(pa, pd);
			mask = n ? ($urandom | 32'h1) & ~32'h2 : 32'h8000_0001;
			wr(REG_SECTORS, mask);
			op(CTRL_ERASE);
			chk(erased, mask);
			rd(REG_STATUS, s);
			chk(s & 32'h1f, exp_st(1'b0, 1'b0, 1'b0, 1'b0));
			rdb(pa, pd);
		end
		// Suspend lands in the window, program elsewhere
		wr(REG_SECTORS, 32'h4);
		wr(REG_CTRL, 32'h1 << CTRL_ERASE);
		wr(REG_CTRL, 32'h1 << CTRL_SUSPEND);
		wait_st(ST_SUSP, 1'b1);
		chk(s & 32'h1f, exp_st(1'b1, 1'b1, 1'b0, 1'b0));
		pa = {5'd5, 16'($urandom)};
		pd = 8'($urandom);
		prog(pa, pd);
		rd(REG_STATUS, s);
		chk(s & 32'h1f, exp_st(1'b1, 1'b1, 1'b0, 1'b0));
		rdb(pa, pd);
		wr(REG_PADDR, 32'h2_0000);
		wr(REG_CTRL, 32'h1 << CTRL_PROGRAM);
		rd(REG_STATUS, s);
		chk(s[ST_REFUSED], 1'b1);
		wr(REG_STATUS, 32'h10);
		op(CTRL_RESUME);
		chk(erased, 32'h4);
		rd(REG_STATUS, s);
		chk(s[4:0], 5'h0);
		// Erase that exceeds its limit, recovered by a pin reset
		fail_mode <= 1'b1;
		wr(REG_SECTORS, 32'h10);
		op(CTRL_ERASE);
		rd(REG_STATUS, s);
		chk(s & 32'h1f, exp_st(1'b0, 1'b0, 1'b1, 1'b0));
		op(CTRL_HWRESET);
		fail_mode <= 1'b0;
		wr(REG_STATUS, 32'h8);
		rd(REG_STATUS, s);
		chk(s[4:0], 5'h0);
		wr(REG_SECTORS, 32'h10);
		op(CTRL_ERASE);
		chk(erased, 32'h10);
		// Resume outside suspension is refused
		wr(REG_CTRL, 32'h1 << CTRL_RESUME);
		rd(REG_STATUS, s);
		chk(s & 32'h1f, exp_st(1'b0, 1'b0, 1'b0, 1'b1));
		print_verdict();
	end
endmodule

// >>> include/flash_host_pkg.sv
// Constants, register map and carrier types of the flash erase host
package flash_host_pkg;

	// Timing at the reference clock
	localparam int CLK_NS      = 40;
	localparam int T_WINDOW_NS = 50000;
	localparam int WINDOW_CYC  = T_WINDOW_NS / CLK_NS;
	localparam int T_SUSP_NS   = 15000;
	localparam int SUSP_CYC    = (T_SUSP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ACC_NS    = 70;
	localparam int SYNC_CYC    = 2;
	localparam int STROBE_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int T_RST_NS    = 500;
	localparam int RST_CYC     = (T_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_W       = $clog2(WINDOW_CYC + 1);
	localparam int TMO_W       = $clog2(SUSP_CYC + 16);
	localparam int RCNT_W      = $clog2(RST_CYC + 1);

	// Register offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_SECTORS = 8'h04;
	localparam logic [7:0] REG_PADDR   = 8'h08;
	localparam logic [7:0] REG_PDATA   = 8'h0c;
	localparam logic [7:0] REG_STATUS  = 8'h10;
	localparam logic [7:0] REG_RDATA   = 8'h14;

	// Control bits
	localparam int CTRL_ERASE   = 0;
	localparam int CTRL_SUSPEND = 1;
	localparam int CTRL_RESUME  = 2;
	localparam int CTRL_PROGRAM = 3;
	localparam int CTRL_READ    = 4;
	localparam int CTRL_HWRESET = 5;

	// Status bits
	localparam int ST_BUSY     = 0;
	localparam int ST_ERASING  = 1;
	localparam int ST_SUSP     = 2;
	localparam int ST_FAIL     = 3;
	localparam int ST_REFUSED  = 4;
	localparam int ST_RDY      = 5;
	localparam int ST_LAST_LSB = 8;

	// Flash status byte bits
	localparam int POLL_STATUS_BIT     = 7;
	localparam int ACTIVITY_TOGGLE_BIT = 6;
	localparam int LIMIT_FAIL_BIT      = 5;

	// Flash command words
	localparam int         ADDR_W    = 21;
	localparam int         SEC_LSB   = 16;
	localparam logic [20:0] UNLOCK_A1 = 21'h005555;
	localparam logic [20:0] UNLOCK_A2 = 21'h002aaa;
	localparam logic [20:0] ANY_ADDR  = 21'h000000;
	localparam logic [7:0] UNLOCK_D1 = 8'haa;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [7:0] ERASE_SET = 8'h80;
	localparam logic [7:0] SEC_ERASE = 8'h30;
	localparam logic [7:0] PROG_SET  = 8'ha0;
	localparam logic [7:0] SUSP_CMD  = 8'hb0;
	localparam logic [7:0] RESUME_CMD = 8'h30;

	typedef struct packed {
		logic        wr;
		logic [20:0] addr;
		logic [7:0]  data;
	} cyc_req_s;

	typedef struct packed {
		logic [20:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe_n;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
	} flash_pins_s;

endpackage
